// file: pkg/fcdo_pkg.sv
// package: register map, field layout and timing constants for flash control
package fcdo_pkg;
  // register byte addresses on the axi4-lite slave
  localparam logic [7:0] ADDR_CLKDIV = 8'h00;
  localparam logic [7:0] ADDR_OPTS = 8'h04;
  localparam logic [7:0] ADDR_KEYCTL = 8'h08;
  localparam logic [7:0] ADDR_KEYDATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // divider register fields
  localparam int DIV_LOADED_BIT = 7;
  localparam int PRESCALE_BIT = 6;
  localparam int DIV_W = 6;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  // options register fields
  localparam int BACKDOOR_KEY_ENABLE_BIT = 7;
  localparam int NORED_BIT = 6;
  localparam logic [7:0] OPTS_MASK = 8'hc3;
  localparam logic [1:0] SEC_OPEN = 2'h2;
  // key sequencing
  localparam int KEY_BYTES = 8;
  localparam logic [3:0] KEY_LAST = 4'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic loaded;
    logic prescale_by_eight;
    logic [5:0] divisor;
  } fcdo_div_t;

  typedef struct packed {
    logic backdoor_key_enable;
    logic vector_redirect_disable;
    logic [3:0] zero;
    logic [1:0] security_code;
  } fcdo_opt_t;
endpackage

// file: logic/fcdo_ctrl.sv
// flash clock divider, options register, security gate and axi4-lite slave
`timescale 1ns/1ps
// Function
// - divider top bit status; low bits write-once
// - loaded flag cleared at reset, set first write
// - erase/program refused until divisor loaded
// - prescale bit selects bus or bus/8
// - divide selected input by divisor plus one
// - timing pulse one bus-clock cycle wide
// - options byte copied from flash at reset
// - options bits 5:2 zero; writes ignored
// - key enable gates eight-byte backdoor unlock
// - debug interface key writes never unlock
// - options bit 6 disables vector redirection
// - code 1:0 unsecured, others secured
// - secured memory blocked for unsecured sources
// - key match or blank check unsecures
// - blocked writes dropped, reads return zero
module fcdo_ctrl
  import fcdo_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // nonvolatile loader (same clock, stable around reset)
  input wire logic [7:0] nonvolatile_options_byte,
  input wire logic [63:0] backdoor_compare_key,
  input wire logic blank_check_pass,
  // flash command side
  input wire logic erase_program_req,
  output logic erase_program_grant,
  output logic erase_program_refused,
  output logic flash_clk_pulse,
  // memory access gate
  input wire logic mem_req,
  input wire logic mem_src_secure,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata_in,
  input wire logic [7:0] mem_rdata_in,
  output logic mem_write_en,
  output logic [7:0] mem_rdata_out,
  // decoded options
  output logic vector_redirect_en,
  output logic secured,
  // key write source: high when issued by the debug interface
  input wire logic key_src_debug
);

  // ***************************************
  // bus channel state
  // ***************************************
  fcdo_div_t div_ff, nxt_div;
  fcdo_opt_t opt_ff, nxt_opt;
  logic [7:0] awaddr_ff;
  logic aw_held_ff, w_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic boot_ff;
  logic key_active_ff;
  logic [3:0] key_idx_ff;
  logic key_ok_ff;
  logic key_debug_seen_ff;
  logic [2:0] pre_cnt_ff;
  logic [5:0] div_cnt_ff;

  assign s_awready = !aw_held_ff && !s_bvalid;
  assign s_wready = !w_held_ff && !s_bvalid;
  wire aw_take = s_awvalid && s_awready;
  wire w_take = s_wvalid && s_wready;
  wire have_aw = aw_held_ff || aw_take;
  wire have_w = w_held_ff || w_take;
  wire wr_go = have_aw && have_w && !s_bvalid;
  wire [7:0] wr_addr = aw_held_ff ? awaddr_ff : s_awaddr;
  wire [31:0] wr_data = w_held_ff ? wdata_ff : s_wdata;
  wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_wstrb;
  wire wr_lane0 = wr_go && wr_strb[0];
  wire wr_div = wr_lane0 && (wr_addr == ADDR_CLKDIV);
  wire wr_keyctl = wr_lane0 && (wr_addr == ADDR_KEYCTL);
  wire wr_keydat = wr_lane0 && (wr_addr == ADDR_KEYDATA);
  wire wr_known = (wr_addr == ADDR_CLKDIV) || (wr_addr == ADDR_OPTS) ||
    (wr_addr == ADDR_KEYCTL) || (wr_addr == ADDR_KEYDATA) ||
    (wr_addr == ADDR_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      aw_held_ff <= have_aw && !wr_go;
      w_held_ff <= have_w && !wr_go;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************
  // divider register
  // ***************************************
  always_comb begin
    nxt_div = div_ff;
    if (wr_div && !div_ff.loaded) begin
      nxt_div.prescale_by_eight = wr_data[PRESCALE_BIT];
      nxt_div.divisor = wr_data[DIV_W-1:0];
    end
    if (wr_div) begin
      nxt_div.loaded = 1'b1;
    end
  end

  // ***************************************
  // options and security
  // ***************************************
  wire key_match = (key_idx_ff == KEY_BYTES[3:0]) && key_ok_ff &&
    !key_debug_seen_ff;
  wire key_close = wr_keyctl && !wr_data[0] && key_active_ff;
  always_comb begin
    nxt_opt = opt_ff;
    // capture options byte after reset release
    if (boot_ff) begin
      nxt_opt = fcdo_opt_t'(nonvolatile_options_byte & OPTS_MASK);
    // key enable gates backdoor unlock; unlock paths
    end else if ((key_close && key_match && opt_ff.backdoor_key_enable)
        || blank_check_pass) begin
      nxt_opt.security_code = SEC_OPEN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
      opt_ff <= '0;
      boot_ff <= 1'b1;
    end else begin
      div_ff <= nxt_div;
      opt_ff <= nxt_opt;
      boot_ff <= 1'b0;
    end
  end

  // ***************************************
  // backdoor key sequencing
  // ***************************************
  // bytes must arrive in order; any mismatch spoils the whole attempt
  wire [7:0] key_byte = backdoor_compare_key[63 - 8*key_idx_ff[2:0] -: 8];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_active_ff <= 1'b0;
      key_idx_ff <= 4'h0;
      key_ok_ff <= 1'b0;
      key_debug_seen_ff <= 1'b0;
    end else if (wr_keyctl) begin
      key_active_ff <= wr_data[0];
      key_idx_ff <= 4'h0;
      key_ok_ff <= 1'b1;
      key_debug_seen_ff <= 1'b0;
    end else if (wr_keydat && key_active_ff) begin
      if (key_src_debug) begin
        key_debug_seen_ff <= 1'b1;
      end
      if (key_idx_ff <= KEY_LAST) begin
        key_ok_ff <= key_ok_ff && (wr_data[7:0] == key_byte);
        key_idx_ff <= key_idx_ff + 4'h1;
      end else begin
        key_ok_ff <= 1'b0;
      end
    end
  end

  // ***************************************
  // flash clock divider
  // ***************************************
  // prescale tick every eighth bus clock when selected
  wire pre_tick = !div_ff.prescale_by_eight || (pre_cnt_ff == PRESCALE_LAST);
  wire div_wrap = pre_tick && (div_cnt_ff == div_ff.divisor);
  always_ff @(posedge aclk) begin
    if (!aresetn || !div_ff.loaded) begin
      pre_cnt_ff <= 3'h0;
      div_cnt_ff <= 6'h00;
      flash_clk_pulse <= 1'b0;
    end else begin
      pre_cnt_ff <= div_ff.prescale_by_eight ? pre_cnt_ff + 3'h1 : 3'h0;
      if (pre_tick) begin
        div_cnt_ff <= div_wrap ? 6'h00 : div_cnt_ff + 6'h01;
      end
      // one pulse per flash clock period
      flash_clk_pulse <= div_wrap;
    end
  end

  assign erase_program_grant = erase_program_req && div_ff.loaded;
  assign erase_program_refused = erase_program_req && !div_ff.loaded;

  // ***************************************
  // decoded options and memory gate
  // ***************************************
  // only 1:0 is unsecured
  assign secured = opt_ff.security_code != SEC_OPEN;
  assign vector_redirect_en = !opt_ff.vector_redirect_disable;
  wire mem_blocked = secured && !mem_src_secure;
  // drop writes, zero reads when blocked
  assign mem_write_en = mem_req && mem_write && !mem_blocked;
  assign mem_rdata_out = mem_blocked ? 8'h00 : mem_rdata_in;
  wire unused_wdata = ^mem_wdata_in;

  // ***************************************
  // read channel
  // ***************************************
  // options read with bits 5:2 zero; writes ignored
  wire [7:0] rd_byte =
    (s_araddr == ADDR_CLKDIV) ? div_ff :
    (s_araddr == ADDR_OPTS) ? (opt_ff & OPTS_MASK) :
    (s_araddr == ADDR_KEYCTL) ? {7'h00, key_active_ff} :
    (s_araddr == ADDR_STATUS) ? {4'h0, key_idx_ff} : 8'h00;
  wire rd_known = (s_araddr == ADDR_CLKDIV) || (s_araddr == ADDR_OPTS) ||
    (s_araddr == ADDR_KEYCTL) || (s_araddr == ADDR_KEYDATA) ||
    (s_araddr == ADDR_STATUS);
  assign s_arready = !s_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= {24'h000000, rd_byte};
      s_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

// file: test/fcdo_assertions.sv
// port checker for the flash control block
`timescale 1ns/1ps
module fcdo_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched ports
  input wire logic erase_program_req,
  input wire logic erase_program_grant,
  input wire logic erase_program_refused,
  input wire logic flash_clk_pulse,
  input wire logic blank_check_pass,
  input wire logic mem_req,
  input wire logic mem_src_secure,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [7:0] mem_rdata_out,
  input wire logic mem_write_en,
  input wire logic vector_redirect_en,
  input wire logic secured
);
  // ***
  // properties
  // ***
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire blk = mem_req && secured && !mem_src_secure;
  ep_excl_a: assert property (
    erase_program_grant |-> erase_program_req && !erase_program_refused)
    else $error("grant out of place");
  ep_keep_a: assert property (
    $past(erase_program_grant) && erase_program_req |-> erase_program_grant)
    else $error("grant lost");
  // divisor 0 without prescale legally pulses every cycle, so tie to load
  pulse_one_a: assert property (
    flash_clk_pulse && erase_program_req |-> !erase_program_refused)
    else $error("pulse before divisor load");
  blk_mem_a: assert property (
    blk |-> mem_rdata_out == 8'h00 && !mem_write_en)
    else $error("blocked access leaked");
  open_mem_a: assert property (
    mem_req && !secured |-> mem_rdata_out == mem_rdata_in)
    else $error("open read altered");
  redir_fix_a: assert property (
    $changed(vector_redirect_en) |-> !$past(aresetn, 2))
    else $error("redirect changed late");
  sec_hold_a: assert property (
    !$rose(secured))
    else $error("relocked without reset");
  blank_unl_a: assert property (
    blank_check_pass |-> ##[1:2] !secured)
    else $error("blank check kept lock");
endmodule

// file: test/fcdo_nvm_model.sv
// model of the nonvolatile options and key store
`timescale 1ns/1ps
module fcdo_nvm_model #(
  parameter logic [63:0] KEY = 64'h0123456789abcdef
) (
  // programming side
  input wire logic aclk,
  input wire logic prog_en,
  input wire logic [7:0] prog_opts,
  // loader side
  output logic [7:0] nonvolatile_options_byte,
  output logic [63:0] backdoor_compare_key
);
  // ***
  // storage
  // ***
  // reprogram before reset
  always_ff @(posedge aclk) begin
    if (prog_en) begin
      nonvolatile_options_byte <= prog_opts;
    end
  end
  assign backdoor_compare_key = KEY;
endmodule

// file: test/tb_flash_clock_div_and_options.sv
// testbench for the flash control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_flash_clock_div_and_options;
  import fcdo_pkg::*;
  localparam logic [63:0] KEY = 64'h0123456789abcdef;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, prog_en;
  logic [7:0] s_awaddr, s_araddr, prog_opts, nonvolatile_options_byte;
  logic [7:0] mem_wdata_in, mem_rdata_in, mem_rdata_out, d, o;
  logic [31:0] s_wdata, s_rdata, rdv;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [63:0] backdoor_compare_key;
  logic blank_check_pass, erase_program_req, erase_program_grant;
  logic erase_program_refused, flash_clk_pulse, mem_req, mem_src_secure;
  logic mem_write, mem_write_en, vector_redirect_en, secured, key_src_debug;
  int error_cnt, checks, seed, n;
  fcdo_nvm_model #(.KEY(KEY)) nvm (.*);
  fcdo_ctrl dut (.*);
  // ***
  // helpers
  // ***
  function automatic int exp_period(logic [7:0] v);
    return (v[5:0] + 1) * (v[6] ? 8 : 1);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
    while (!s_bvalid) @(posedge aclk);
    resp = s_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge aclk);
    rdv = s_rdata;
    resp = s_rresp;
  endtask
  task automatic boot(input logic [7:0] v);
    prog_opts <= v;
    prog_en <= 1'b1;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    prog_en <= 1'b0;
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    finish_test;
  end
  // ***
  // scenarios
  // ***
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_arvalid, prog_en, s_awaddr} = '0;
    {s_araddr, prog_opts, mem_wdata_in, mem_rdata_in, s_wdata} = '0;
    {blank_check_pass, erase_program_req, mem_req, mem_write} = '0;
    {mem_src_secure, key_src_debug} = '0;
    {s_bready, s_rready, s_wstrb} = 6'h3f;
    seed = 4;
    for (int i = 0; i < 4; i++) begin
      o = 8'($random(seed));
      o[1:0] = i[1:0];
      boot(o);
      rd(ADDR_OPTS);
      `CHK("opts", o & OPTS_MASK, rdv[7:0])
      `CHK("secured", i != 2, secured)
      `CHK("redirect", !o[6], vector_redirect_en)
      wr(ADDR_OPTS, {24'h0, ~o});
      `CHK("opts wr resp", RESP_OKAY, resp)
      rd(ADDR_OPTS);
      `CHK("opts ro", o & OPTS_MASK, rdv[7:0])
    end
    for (int p = 0; p < 2; p++) begin
      boot(8'h02);
      erase_program_req <= 1'b1;
      rd(ADDR_CLKDIV);
      `CHK("refused", 1'b1, erase_program_refused)
      `CHK("div reset", 8'h00, rdv[7:0])
      d = 8'($random(seed));
      // prescaled pass lands near 195-198 kHz at 100 MHz
      d = p[0] ? {2'b01, 5'h1f, d[0]} : {2'b00, 4'h0, d[1], 1'b1};
      wr(ADDR_CLKDIV, {24'h0, d});
      // only request erase/program with an in-range flash clock
      erase_program_req <= p[0];
      wr(ADDR_CLKDIV, 32'h3e);
      `CHK("div wr resp", RESP_OKAY, resp)
      rd(ADDR_CLKDIV);
      `CHK("divider", d | 8'h80, rdv[7:0])
      `CHK("grant", p[0], erase_program_grant)
      n = 0;
      while (!flash_clk_pulse) @(posedge aclk);
      do begin
        @(posedge aclk);
        n++;
      end while (!flash_clk_pulse);
      `CHK("period", exp_period(d), n)
    end
    rd(8'h14);
    `CHK("unmapped", RESP_SLVERR, resp)
    for (int k = 0; k < 3; k++) begin
      boot({k != 2, 7'h03});
      key_src_debug <= (k == 1);
      wr(ADDR_KEYCTL, 32'h1);
      for (int b = 0; b < KEY_BYTES; b++) begin
        wr(ADDR_KEYDATA, {24'h0, KEY[63 - 8 * b -: 8]});
      end
      wr(ADDR_KEYCTL, 32'h0);
      @(posedge aclk);
      `CHK("key lock", k != 0, secured)
    end
    mem_rdata_in <= 8'($random(seed));
    mem_req <= 1'b1;
    mem_write <= 1'b1;
    @(posedge aclk);
    `CHK("blocked rd", 8'h00, mem_rdata_out)
    `CHK("blocked wr", 1'b0, mem_write_en)
    blank_check_pass <= 1'b1;
    @(posedge aclk);
    blank_check_pass <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("blank", 1'b0, secured)
    `CHK("open rd", mem_rdata_in, mem_rdata_out)
    `CHK("open wr", 1'b1, mem_write_en)
    boot(8'h03);
    `CHK("relock", 1'b1, secured)
    finish_test;
  end
endmodule
bind fcdo_ctrl fcdo_assertions chk (.*);
